// ### core/sffc_top.sv
// Frame-format register with the framer that obeys it.
//
// How it works
// [RL1] Format register is eight bits, zero after reset and low-power entry.
// [RL2] Software reads the format register at any time, and writes it at any time except while low_power_in is high.
// [RL3] Bit 7 low gives asynchronous framing, high gives synchronous.
// [RL4] Bit 6 picks 8 or 7 bits asynchronously; synchronous is always 8.
// [RL5] Seven-bit characters drop the top bit of the holding byte.
// [RL6] Parity and multiprocessor both set give 5 bits asynchronously, top three dropped.
// [RL7] Bit 5 enables parity append and check, asynchronous only.
// [RL8] Bit 4 picks even or odd parity when parity is in use.
// [RL9] Parity makes ones count even or odd; receiver checks the same.
// [RL10] Bit 3 gives one or two high stop bits, none when synchronous.
// [RL11] Receiver checks only the first stop bit; a low next bit starts.
// [RL12] Bit 2 enables multiprocessor mode, which overrides parity settings.
// [RL13] Software keeps multiprocessor mode clear in synchronous mode.
// [RL14] Bits 1:0 pick system clock, sub-clock, divide by 16 or 64.
// [RL15] Sub-clock code halves the sub-clock except in sub modes.
// [RL16] Sub modes need the CPU on the halved sub-clock; software's job.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module sffc_top
    import sffc_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       low_power_in,
    input  wire logic       sub_mode_in,
    input  wire logic       sub_tick_in,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       tx_mpb_in,
    input  wire logic       tx_load_in,
    output logic            tx_ready_out,
    output logic            txd_out,
    input  wire logic       rxd_in,
    output logic      [7:0] rx_data_out,
    output logic            rx_valid_out,
    output logic            rx_parity_err_out,
    output logic            rx_frame_err_out,
    output logic            rx_mpb_out
);
    // ****************
    // State
    // ****************
    typedef struct packed {
        logic [7:0]  fmt;
        sffc_frame_t tx_st;
        logic [7:0]  tx_sh;
        logic [2:0]  tx_idx;
        logic [7:0]  tx_cnt;
        logic        tx_xbit;
        logic        tx_more;
        logic        txd;
        logic        tx_ready;
        sffc_frame_t rx_st;
        logic [7:0]  rx_sh;
        logic [2:0]  rx_idx;
        logic [7:0]  rx_cnt;
        logic        rx_xbit;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic        rx_perr;
        logic        rx_ferr;
        logic        rx_mpb;
        logic [7:0]  rdata;
    } sffc_state_t;

    sffc_state_t cur;
    sffc_state_t next_cur;
    logic        src_tick;
    logic [7:0]  mask;
    logic [7:0]  tx_bits;
    logic [7:0]  rx_just;
    logic        tx_end;
    logic        rx_end;
    logic [2:0]  last_idx;
    logic        use_xbit;

    sffc_cfg_if cfg ();

    // ****************
    // Helpers
    // ****************
    sffc_decode u_dec (
        .cfg (cfg.dec)
    );

    sffc_clksel u_cks (
        .sys_clk_in   (sys_clk_in),
        .arst_n_in    (arst_n_in),
        .cks_in       (cur.fmt[BIT_CKS_HI:BIT_CKS_LO]),
        .sub_mode_in  (sub_mode_in),
        .sub_tick_in  (sub_tick_in),
        .src_tick_out (src_tick)
    );

    assign cfg.fmt = cur.fmt;

    // ****************
    // Next-state logic
    // ****************
    always_comb begin
        next_cur          = cur;
        next_cur.rx_valid = 1'b0;
        next_cur.rdata    = 8'h00;
        // Unused top bits are forced to zero before sending.
        mask      = 8'hFF >> (LEN_8 - cfg.nbits);                 // [RL5] [RL6]
        tx_bits   = tx_data_in & mask;
        last_idx  = 3'(cfg.nbits - 4'h1);
        use_xbit  = cfg.par_en || cfg.mp_en;
        rx_just   = cur.rx_sh >> (LEN_8 - cfg.nbits);
        tx_end    = src_tick && (cur.tx_cnt == BIT_LAST);
        rx_end    = src_tick && (cur.rx_cnt == BIT_LAST);

        // Register port; the read answer stands for one cycle only.
        if (reg_rd_in) begin                                       // [RL2]
            unique case (reg_addr_in)
                ADDR_FMT:  next_cur.rdata = cur.fmt;
                ADDR_STAT: next_cur.rdata = {3'h0, cur.rx_mpb,
                                             cur.rx_ferr, cur.rx_perr,
                                             cur.rx_st != F_IDLE,
                                             cur.tx_st != F_IDLE};
                default:   next_cur.rdata = 8'h00;
            endcase
        end
        if (reg_wr_in && reg_addr_in == ADDR_FMT) begin
            next_cur.fmt = reg_wdata_in;                           // [RL2]
        end

        // ****************
        // Transmitter
        // ****************
        if (src_tick) begin
            next_cur.tx_cnt = cur.tx_cnt + 8'h01;
        end
        unique case (cur.tx_st)
            F_IDLE: begin
                next_cur.tx_cnt = 8'h00;
                next_cur.txd    = 1'b1;
                if (tx_load_in && cur.tx_ready) begin
                    next_cur.tx_sh   = tx_bits;
                    next_cur.tx_idx  = 3'h0;
                    next_cur.tx_more = cfg.two_stop;
                    // Even parity makes the ones count even, odd makes it odd.
                    next_cur.tx_xbit = cfg.mp_en ? tx_mpb_in
                                       : (^tx_bits) ^ cfg.par_odd; // [RL9]
                    if (cfg.sync) begin
                        next_cur.tx_st = F_DATA;                   // [RL3]
                        next_cur.txd   = tx_bits[0];
                    end else begin
                        next_cur.tx_st = F_START;
                        next_cur.txd   = 1'b0;
                    end
                end
            end
            F_START: begin
                if (tx_end) begin
                    next_cur.tx_cnt = 8'h00;
                    next_cur.tx_st  = F_DATA;
                    next_cur.txd    = cur.tx_sh[0];
                end
            end
            F_DATA: begin
                if (tx_end) begin
                    next_cur.tx_cnt = 8'h00;
                    next_cur.tx_sh  = cur.tx_sh >> 1;
                    next_cur.tx_idx = cur.tx_idx + 3'h1;
                    next_cur.txd    = cur.tx_sh[1];
                    if (cur.tx_idx == last_idx) begin
                        next_cur.txd = 1'b1;
                        if (cfg.sync) begin
                            next_cur.tx_st = F_IDLE;               // [RL10]
                        end else if (use_xbit) begin
                            next_cur.tx_st = F_EXTRA;              // [RL7]
                            next_cur.txd   = cur.tx_xbit;
                        end else begin
                            next_cur.tx_st = F_STOP;
                        end
                    end
                end
            end
            F_EXTRA: begin
                if (tx_end) begin
                    next_cur.tx_cnt = 8'h00;
                    next_cur.tx_st  = F_STOP;
                    next_cur.txd    = 1'b1;
                end
            end
            F_STOP: begin
                if (tx_end) begin
                    next_cur.tx_cnt  = 8'h00;
                    next_cur.tx_more = 1'b0;
                    if (!cur.tx_more) begin
                        next_cur.tx_st = F_IDLE;                   // [RL10]
                    end
                end
            end
            default: begin
                next_cur.tx_st = F_IDLE;
            end
        endcase
        next_cur.tx_ready = (next_cur.tx_st == F_IDLE);

        // ****************
        // Receiver, asynchronous framing only
        // ****************
        if (src_tick) begin
            next_cur.rx_cnt = cur.rx_cnt + 8'h01;
        end
        unique case (cur.rx_st)
            F_IDLE: begin
                next_cur.rx_cnt = 8'h00;
                if (!rxd_in && !cfg.sync) begin
                    next_cur.rx_st = F_START;
                end
            end
            F_START: begin
                // Recheck at mid-bit so a glitch is not taken as a start.
                if (src_tick && cur.rx_cnt == HALF_LAST) begin
                    next_cur.rx_cnt = 8'h00;
                    next_cur.rx_idx = 3'h0;
                    next_cur.rx_st  = rxd_in ? F_IDLE : F_DATA;
                end
            end
            F_DATA: begin
                if (rx_end) begin
                    next_cur.rx_cnt = 8'h00;
                    next_cur.rx_sh  = {rxd_in, cur.rx_sh[7:1]};
                    next_cur.rx_idx = cur.rx_idx + 3'h1;
                    if (cur.rx_idx == last_idx) begin
                        next_cur.rx_st = use_xbit ? F_EXTRA : F_STOP;
                    end
                end
            end
            F_EXTRA: begin
                if (rx_end) begin
                    next_cur.rx_cnt  = 8'h00;
                    next_cur.rx_xbit = rxd_in;
                    next_cur.rx_st   = F_STOP;
                end
            end
            F_STOP: begin
                if (rx_end) begin
                    next_cur.rx_data  = rx_just;
                    next_cur.rx_valid = 1'b1;
                    next_cur.rx_ferr  = !rxd_in;                   // [RL11]
                    next_cur.rx_perr  = cfg.par_en
                        && ((^rx_just) ^ cur.rx_xbit ^ cfg.par_odd); // [RL9]
                    next_cur.rx_mpb   = cfg.mp_en && cur.rx_xbit;  // [RL12]
                    // A second stop slot is not waited for, so a low there
                    // is seen as the next start bit.
                    next_cur.rx_st    = F_IDLE;                    // [RL11]
                end
            end
            default: begin
                next_cur.rx_st = F_IDLE;
            end
        endcase

        // ****************
        // Low-power entry clears the format and aborts any frame
        // ****************
        if (low_power_in) begin
            next_cur.fmt      = FMT_RESET;                         // [RL1]
            next_cur.tx_st    = F_IDLE;
            next_cur.tx_ready = 1'b1;
            next_cur.txd      = 1'b1;
            next_cur.rx_st    = F_IDLE;
        end
    end

    // ****************
    // Registers
    // ****************
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cur          <= '0;
            cur.fmt      <= FMT_RESET;                             // [RL1]
            cur.tx_st    <= F_IDLE;
            cur.rx_st    <= F_IDLE;
            cur.txd      <= 1'b1;
            cur.tx_ready <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata_out     = cur.rdata;
    assign tx_ready_out      = cur.tx_ready;
    assign txd_out           = cur.txd;
    assign rx_data_out       = cur.rx_data;
    assign rx_valid_out      = cur.rx_valid;
    assign rx_parity_err_out = cur.rx_perr;
    assign rx_frame_err_out  = cur.rx_ferr;
    assign rx_mpb_out        = cur.rx_mpb;
endmodule

// ### core/sffc_pkg.sv
// Constants and types shared by the serial frame-format block.
package sffc_pkg;
    // ****************
    // Register map
    // ****************
    localparam logic [7:0] ADDR_FMT   = 8'h00;
    localparam logic [7:0] ADDR_STAT  = 8'h01;
    localparam logic [7:0] FMT_RESET  = 8'h00;
    // ****************
    // Frame-format field positions
    // ****************
    localparam int         BIT_SYNC   = 7;
    localparam int         BIT_CHR    = 6;
    localparam int         BIT_PAR_EN = 5;
    localparam int         BIT_PAR_OD = 4;
    localparam int         BIT_STOP2  = 3;
    localparam int         BIT_MP     = 2;
    localparam int         BIT_CKS_HI = 1;
    localparam int         BIT_CKS_LO = 0;
    // ****************
    // Clock source codes and timing counts
    // ****************
    localparam logic [1:0] CKS_SYS    = 2'h0;
    localparam logic [1:0] CKS_SUB    = 2'h1;
    localparam logic [1:0] CKS_DIV16  = 2'h2;
    localparam logic [1:0] CKS_DIV64  = 2'h3;
    localparam logic [5:0] PRE_LAST16 = 6'h0F;
    localparam logic [5:0] PRE_LAST64 = 6'h3F;
    // Source ticks per bit; stands in for the excluded bit-rate counter.
    localparam logic [7:0] BIT_LAST   = 8'h0F;
    localparam logic [7:0] HALF_LAST  = 8'h07;
    localparam logic [3:0] LEN_8      = 4'h8;
    localparam logic [3:0] LEN_7      = 4'h7;
    localparam logic [3:0] LEN_5      = 4'h5;
    // ****************
    // Frame sequencer states, Gray coded along the usual path from idle to stop
    // ****************
    typedef enum logic [2:0] {
        F_IDLE  = 3'h0,
        F_START = 3'h1,
        F_DATA  = 3'h3,
        F_EXTRA = 3'h2,
        F_STOP  = 3'h6
    } sffc_frame_t;
endpackage

// ### core/sffc_cfg_if.sv
// Carrier for the frame-format byte and its decoded settings.
`timescale 1ns/1ns
interface sffc_cfg_if;
    logic [7:0] fmt;
    logic       sync;
    logic       par_en;
    logic       par_odd;
    logic       two_stop;
    logic       mp_en;
    logic [3:0] nbits;
    modport dec  (input fmt, output sync, par_en, par_odd, two_stop,
                  mp_en, nbits);
    modport core (output fmt, input sync, par_en, par_odd, two_stop,
                  mp_en, nbits);
endinterface

// ### core/sffc_decode.sv
// Decoder from the frame-format byte to the settings the framer uses.
`timescale 1ns/1ns
module sffc_decode
    import sffc_pkg::*;
(
    sffc_cfg_if.dec cfg
);
    logic five;

    always_comb begin
        cfg.sync     = cfg.fmt[BIT_SYNC];                          // [RL3]
        // Five-bit characters are the parity-plus-multiprocessor code.
        five         = !cfg.sync && cfg.fmt[BIT_PAR_EN]
                       && cfg.fmt[BIT_MP];                         // [RL6]
        if (cfg.sync || (!cfg.fmt[BIT_CHR] && !five)) begin
            cfg.nbits = LEN_8;                                     // [RL4]
        end else if (five) begin
            cfg.nbits = LEN_5;                                     // [RL6]
        end else begin
            cfg.nbits = LEN_7;                                     // [RL4]
        end
        cfg.mp_en    = !cfg.sync && cfg.fmt[BIT_MP];               // [RL12]
        cfg.par_en   = !cfg.sync && cfg.fmt[BIT_PAR_EN]
                       && !cfg.fmt[BIT_MP];                        // [RL7]
        cfg.par_odd  = cfg.par_en && cfg.fmt[BIT_PAR_OD];          // [RL8]
        cfg.two_stop = !cfg.sync && cfg.fmt[BIT_STOP2];            // [RL10]
    end
endmodule

// ### core/sffc_clksel.sv
// Source-clock selector feeding the bit timing of the framer.
`timescale 1ns/1ns
module sffc_clksel
    import sffc_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic [1:0] cks_in,
    input  wire logic       sub_mode_in,
    input  wire logic       sub_tick_in,
    output logic            src_tick_out
);
    typedef struct packed {
        logic [5:0] pre;
        logic       half;
        logic       tick;
    } sffc_cs_t;

    sffc_cs_t cur;
    sffc_cs_t next_cur;

    always_comb begin
        next_cur     = cur;
        next_cur.pre = cur.pre + 6'h01;
        if (sub_tick_in) begin
            next_cur.half = !cur.half;
        end
        unique case (cks_in)                                       // [RL14]
            CKS_SYS:   next_cur.tick = 1'b1;
            // Halved sub-clock in active and sleep, full rate in sub modes.
            CKS_SUB:   next_cur.tick = sub_tick_in
                                       && (sub_mode_in || cur.half); // [RL15]
            CKS_DIV16: next_cur.tick = (cur.pre[3:0] == PRE_LAST16[3:0]);
            CKS_DIV64: next_cur.tick = (cur.pre == PRE_LAST64);
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign src_tick_out = cur.tick;
endmodule

// ### verification/sffc_top_properties.sv
// Port-level checks for the serial frame-format block.
`timescale 1ns/1ns
module sffc_top_properties
    import sffc_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_rdata_out,
    input  wire logic       low_power_in,
    input  wire logic       tx_load_in,
    input  wire logic       tx_ready_out,
    input  wire logic       txd_out,
    input  wire logic       rx_valid_out,
    input  wire logic [7:0] rx_data_out
);
    // ****************
    // Shadow of the format register and properties
    // ****************
    logic [7:0] fmt;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fmt <= FMT_RESET;
        end else if (low_power_in) begin
            fmt <= FMT_RESET;
        end else if (reg_wr_in && reg_addr_in == ADDR_FMT) begin
            fmt <= reg_wdata_in;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    rdata_idle_a: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    fmt_readback_a: assert property (
        reg_rd_in && reg_addr_in == ADDR_FMT |=> reg_rdata_out == $past(fmt))
        else $error("format readback wrong");
    unmapped_read_a: assert property (
        reg_rd_in && reg_addr_in > ADDR_STAT |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    stop_high_a: assert property (
        $rose(tx_ready_out) && !fmt[BIT_SYNC] && !$past(low_power_in)
        && !$past(low_power_in, 2) |-> txd_out)
        else $error("frame ended with line low");
    tx_start_a: assert property (
        tx_load_in && tx_ready_out && !low_power_in && !fmt[BIT_SYNC]
        |=> !tx_ready_out && !txd_out)
        else $error("no start bit after load");
    start_width_a: assert property (
        $fell(tx_ready_out) && !fmt[BIT_SYNC] && fmt[1:0] == CKS_SYS
        |-> !txd_out [*8])
        else $error("start bit too short");
    lp_abort_a: assert property (
        low_power_in |-> ##[1:2] tx_ready_out)
        else $error("low power did not stop transmitter");
    rx_pulse_a: assert property (
        rx_valid_out |=> !rx_valid_out)
        else $error("receive valid held too long");
    rx_hold_a: assert property (
        !rx_valid_out |-> $stable(rx_data_out))
        else $error("receive data changed without valid");
endmodule
bind sffc_top sffc_top_properties u_props (
    .sys_clk_in    (sys_clk_in),
    .arst_n_in     (arst_n_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .low_power_in  (low_power_in),
    .tx_load_in    (tx_load_in),
    .tx_ready_out  (tx_ready_out),
    .txd_out       (txd_out),
    .rx_valid_out  (rx_valid_out),
    .rx_data_out   (rx_data_out)
);

// ### verification/sffc_peer.sv
// Far-end asynchronous sender that drives the receive line.
`timescale 1ns/1ns
module sffc_peer (
    input  wire logic clk_in,
    output logic      rxd_out
);
    // The line idles high between frames, as a remote UART leaves it.
    initial rxd_out = 1'b1;
    // Sixteen clocks a bit, first bit of the vector sent first.
    task automatic send(input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            rxd_out <= bits[i];
            repeat (15) @(posedge clk_in);
        end
        @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask
endmodule

// ### verification/test_sffc_top.sv
// Self-checking bench for the serial frame-format block.
`timescale 1ns/1ns
module test_sffc_top
    import sffc_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, tdata = 8'h00, rdata, rxb;
    logic        lp = 1'b0, smode = 1'b0, stick = 1'b0, tmpb = 1'b0;
    logic        tload = 1'b0, tready, txd, rxd, rxv, perr, ferr, rmpb;
    int unsigned bad_count = 0;
    int unsigned samples_checked = 0;
    logic [31:0] seed = 32'h7914;
    logic [1:0]  sdiv = 2'h0;

    always #4 clk = ~clk;
    // Sub-clock stand-in: one tick every four system clocks.
    always @(posedge clk) begin
        sdiv <= sdiv + 2'h1;
        stick <= (sdiv == 2'h3);
    end

    sffc_top dut (
        .sys_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .low_power_in(lp), .sub_mode_in(smode),
        .sub_tick_in(stick), .tx_data_in(tdata), .tx_mpb_in(tmpb),
        .tx_load_in(tload), .tx_ready_out(tready), .txd_out(txd),
        .rxd_in(rxd), .rx_data_out(rxb), .rx_valid_out(rxv),
        .rx_parity_err_out(perr), .rx_frame_err_out(ferr),
        .rx_mpb_out(rmpb)
    );
    sffc_peer peer (.clk_in(clk), .rxd_out(rxd));

    // ****************
    // Expectations, comparisons and bus tasks
    // ****************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int width(input logic [7:0] f);
        if (f[BIT_SYNC]) return 8;
        if (f[BIT_PAR_EN] && f[BIT_MP]) return 5;
        return f[BIT_CHR] ? 7 : 8;
    endfunction
    // Line bits of one character, first bit on the wire in bit 0.
    function automatic void frame(input logic [7:0] f, input logic [7:0] d,
                                  input logic m, output logic [31:0] b,
                                  output int n);
        int w;
        w = width(f);
        b = 32'h0;
        n = f[BIT_SYNC] ? 0 : 1;
        for (int i = 0; i < w; i++) b[n + i] = d[i];
        n += w;
        if (!f[BIT_SYNC]) begin
            if (f[BIT_MP] || f[BIT_PAR_EN]) begin
                b[n] = f[BIT_MP] ? m : ^(d & (8'hFF >> (8 - w)))
                                      ^ f[BIT_PAR_OD];
                n++;
            end
            b[n] = 1'b1;
            b[n + 1] = f[BIT_STOP2];
            n += f[BIT_STOP2] ? 2 : 1;
        end
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_span(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("ERROR at %0t: span %0d not in %0d..%0d", $time,
                     got, lo, hi);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic load(input logic [7:0] d, input logic m);
        @(posedge clk);
        tdata <= d;
        tmpb <= m;
        tload <= 1'b1;
        @(posedge clk);
        tload <= 1'b0;
    endtask
    task automatic tx_case(input logic [7:0] f);
        logic [31:0] r, exp, got;
        int n;
        r = rnd();
        got = 32'h0;
        reg_wr(ADDR_FMT, f);
        frame(f, r[7:0], r[8], exp, n);
        load(r[7:0], r[8]);
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            got[i] = txd;
            if (i == n - 1) chk({31'h0, tready}, 32'h0);
            repeat (16) @(posedge clk);
        end
        chk(got, exp);
        chk({31'h0, tready}, 32'h1);
        $display("tx format %h done", f);
    endtask
    // Start-bit length measures the source clock; p is clocks per tick.
    task automatic clk_case(input logic [7:0] f, input logic sm, input int p);
        logic [7:0] v;
        int cnt = 0;
        smode <= sm;
        reg_wr(ADDR_FMT, f);
        load(8'hFF, 1'b1);
        @(posedge clk);
        while (txd === 1'b0 && cnt < 2000) begin
            @(posedge clk);
            cnt++;
        end
        chk_span(cnt, 15 * p, 16 * p + 2);
        lp <= 1'b1;
        repeat (2) @(posedge clk);
        lp <= 1'b0;
        reg_rd(ADDR_FMT, v);
        chk({24'h0, v}, {24'h0, FMT_RESET});
        $display("clock code %h sub %b done", f[1:0], sm);
    endtask
    task automatic wait_rx(input logic [7:0] d, input logic pe,
                           input logic fe, input logic [7:0] f,
                           input logic m);
        int k = 0;
        @(posedge clk);
        while (rxv !== 1'b1 && k < 600) begin
            @(posedge clk);
            k++;
        end
        chk({31'h0, rxv}, 32'h1);
        chk({24'h0, rxb}, {24'h0, d & (8'hFF >> (8 - width(f)))});
        chk({30'h0, perr, ferr}, {30'h0, pe, fe});
        if (f[BIT_MP]) chk({31'h0, rmpb}, {31'h0, m});
    endtask
    // Kind 1 corrupts the parity bit, kind 2 the stop bit.
    task automatic rx_case(input logic [7:0] f, input int kind);
        logic [31:0] r, b;
        int n;
        r = rnd();
        reg_wr(ADDR_FMT, f);
        frame(f, r[7:0], r[8], b, n);
        if (kind == 1) b[1 + width(f)] = ~b[1 + width(f)];
        if (kind == 2) b[n - 1] = 1'b0;
        fork
            peer.send(b, n);
            wait_rx(r[7:0], kind == 1, kind == 2, f, r[8]);
        join
        repeat (300) @(posedge clk);
        $display("rx format %h kind %0d done", f, kind);
    endtask

    // ****************
    // Test sequence
    // ****************
    initial begin
        logic [7:0] v;
        logic [31:0] r, b1, b2;
        logic [7:0] fmts [8] = '{8'h00, 8'h20, 8'h70, 8'h28, 8'h34,
                                 8'h44, 8'hB8, 8'hC0};
        int n;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(ADDR_FMT, v);
        chk({24'h0, v}, {24'h0, FMT_RESET});
        chk({30'h0, tready, txd}, 32'h3);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            r[2] = r[2] && !r[7];
            reg_wr(ADDR_FMT, r[7:0]);
            reg_wr(8'h07, r[15:8]);
            reg_rd(ADDR_FMT, v);
            chk({24'h0, v}, {24'h0, r[7:0]});
            reg_rd(8'h05, v);
            chk({24'h0, v}, 32'h0);
        end
        $display("register access done");
        foreach (fmts[i]) tx_case(fmts[i]);
        clk_case(8'h00, 1'b0, 1);
        clk_case(8'h02, 1'b0, 16);
        clk_case(8'h03, 1'b0, 64);
        clk_case(8'h01, 1'b0, 8);
        clk_case(8'h01, 1'b1, 4);
        smode <= 1'b0;
        rx_case(8'h00, 0);
        rx_case(8'h20, 0);
        rx_case(8'h30, 1);
        rx_case(8'h70, 0);
        rx_case(8'h34, 0);
        rx_case(8'h44, 0);
        rx_case(8'h20, 2);
        reg_rd(ADDR_STAT, v);
        chk({24'h0, v}, 32'h8);
        // Two-stop format, sender uses one stop bit back to back.
        r = rnd();
        reg_wr(ADDR_FMT, 8'h08);
        frame(8'h00, r[7:0], 1'b0, b1, n);
        frame(8'h00, r[15:8], 1'b0, b2, n);
        fork
            peer.send((b2 << 10) | b1, 20);
            begin
                wait_rx(r[7:0], 1'b0, 1'b0, 8'h08, 1'b0);
                wait_rx(r[15:8], 1'b0, 1'b0, 8'h08, 1'b0);
            end
        join
        $display("back to back receive done");
        test_done();
    end
    initial begin
        #400_000;
        bad_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        test_done();
    end
endmodule
